// >>> inc/flash_host_params.svh
// Timing constants for the parallel flash host controller
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define T_WP_NS 60
`define T_WPH_NS 30
`define T_AVWH_NS 55
`define T_DVWH_NS 50
`define T_ACC_NS 75
`define T_GLQV_NS 25
`define T_APA_NS 25
`define T_WHGL_NS 35
`define T_GHQZ_NS 15
`define T_EHQZ_NS 25
`define T_RST_LOW_NS 100
`define T_PHWL_SMALL_NS 150
`define T_PHWL_MED_NS 180
`define T_PHWL_LARGE_NS 210
`define T_WIDTH_NS 1000
`define T_WHRL_NS 500
`define PAGE_WORDS 8
`define CS_ENABLE 3'b000
`define CS_DISABLE 3'b111
`endif

// >>> inc/flash_host_pkg.sv
// Types shared by the parallel flash host controller
package flash_host_pkg;
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_WIDTH = 2'b10,
        OP_RESET = 2'b11
    } op_t;

    typedef struct packed {
        op_t op;
        logic nonarray;
        logic byte_mode;
        logic [23:0] addr;
        logic [15:0] wdata;
    } req_t;

    typedef struct packed {
        logic [2:0] cs;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic wide;
    } pins_t;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_RECOVER = 4'h1,
        ST_IDLE = 4'h2,
        ST_WSETUP = 4'h3,
        ST_WPULSE = 4'h4,
        ST_WHIGH = 4'h5,
        ST_RACC = 4'h6,
        ST_RPAGE = 4'h7,
        ST_RFLOAT = 4'h8,
        ST_WIDTH = 4'h9
    } state_t;
endpackage

// >>> design/flash_wait_timer.sv
// Down-counting wait timer that loads a cycle count
`timescale 1ns/1ps
`default_nettype none
module flash_wait_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    output logic done_o
);
    logic [WIDTH-1:0] cnt_q;

    initial begin
        if (WIDTH < 2) begin
            $error("WIDTH too small");
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// >>> design/flash_host.sv
// Host controller driving a clockless parallel flash through its pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"
// Notes on behaviour
// - Only the enabling select combination selects.
// - Write strobe controls writes; select frames them.
// - Write pulse low at least 60 ns.
// - Write strobe high at least 30 ns.
// - Address 55 ns, data 50 ns setup.
// - Output enable may lag select safely.
// - Wait 150/180/210 ns after reset release.
// - Wait 35 ns after write before read.
// - Array read after write waits full access.
// - Hold program enable until status clean.
// - Never assert output and write enables together.
module flash_host
    import flash_host_pkg::*;
#(
    parameter int DENSITY = 2,
    parameter int ADDR_W = 24,
    parameter bit PAGE_MODE = 1'b1
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire flash_host_pkg::req_t REQ_I,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    output logic [15:0] RDATA_O,
    output logic RDATA_VALID_O,
    input wire logic PROG_ENABLE_REQ_I,
    input wire logic [15:0] FLASH_DQ_I,
    output logic [15:0] FLASH_DQ_O,
    output logic FLASH_DQ_OE_O,
    input wire logic FLASH_STATUS_OUTPUT_PIN_I,
    output logic [ADDR_W-1:0] FLASH_ADDR_O,
    output logic [2:0] FLASH_CHIP_SELECT_O,
    output logic FLASH_OE_N_O,
    output logic FLASH_WE_N_O,
    output logic FLASH_RESET_POWERDOWN_N_O,
    output logic FLASH_WIDE_O,
    output logic FLASH_PROGRAM_ENABLE_INPUT_O,
    output logic BUSY_O
);
    import flash_host_pkg::*;

    function automatic logic [7:0] cyc(input int ns);
        int c;
        c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return 8'(c);
    endfunction

    localparam logic [7:0] C_WP = cyc(`T_WP_NS);
    localparam logic [7:0] C_WPH = cyc(`T_WPH_NS);
    localparam logic [7:0] C_SETUP = cyc(`T_AVWH_NS - `T_DVWH_NS);
    localparam logic [7:0] C_ACC = cyc(`T_ACC_NS);
    localparam logic [7:0] C_APA = PAGE_MODE ? cyc(`T_APA_NS) : C_ACC;
    localparam logic [7:0] C_WHGL = cyc(`T_WHGL_NS);
    localparam logic [7:0] C_FLOAT = cyc(`T_EHQZ_NS);
    localparam logic [7:0] C_RSTLOW = cyc(`T_RST_LOW_NS);
    localparam logic [7:0] C_WIDTH = cyc(`T_WIDTH_NS);
    localparam logic [7:0] C_STS = cyc(`T_WHRL_NS);
    localparam logic [7:0] C_RECOVER = (DENSITY == 0) ?
        cyc(`T_PHWL_SMALL_NS) : (DENSITY == 1) ?
        cyc(`T_PHWL_MED_NS) : cyc(`T_PHWL_LARGE_NS);
    localparam int PAGE_BITS = $clog2(`PAGE_WORDS);

    initial begin
        if (DENSITY < 0 || DENSITY > 2 || ADDR_W < 4 || ADDR_W > 24) begin
            $error("Unsupported DENSITY or ADDR_W");
        end
    end

    state_t state_q;
    pins_t pins_q;
    logic load;
    logic [7:0] load_cnt;
    logic wait_done;
    logic after_write_q;
    logic page_open_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] wdata_q;
    logic dq_oe_q;
    logic rvalid_q;
    logic [15:0] rdata_q;
    logic [1:0] sts_sync_q;
    logic [15:0] dq_meta_q;
    logic [15:0] dq_sync_q;
    logic sts_busy_q;
    logic [7:0] sts_cnt_q;
    logic pe_q;
    logic accept;

    assign accept = (state_q == ST_IDLE) && REQ_VALID_I;

    flash_wait_timer #(.WIDTH(8)) u_timer (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .load_i(load),
        .count_i(load_cnt),
        .done_o(wait_done)
    );

    // Pin inputs pass two flip-flops
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sts_sync_q <= 2'b11;
            dq_meta_q <= 16'h0000;
            dq_sync_q <= 16'h0000;
        end else begin
            sts_sync_q <= {sts_sync_q[0], FLASH_STATUS_OUTPUT_PIN_I};
            dq_meta_q <= FLASH_DQ_I;
            dq_sync_q <= dq_meta_q;
        end
    end

    // Sequencer: load count and next state
    always_comb begin
        load = 1'b0;
        load_cnt = 8'h00;
        case (state_q)
            ST_RESET: begin
                load = wait_done;
                load_cnt = C_RECOVER;
            end
            ST_IDLE: begin
                if (accept) begin
                    load = 1'b1;
                    case (REQ_I.op)
                        OP_WRITE: load_cnt = C_SETUP;
                        OP_WIDTH: load_cnt = C_WIDTH;
                        OP_RESET: load_cnt = C_RSTLOW;
                        default: begin
                            load_cnt = (page_open_q && !REQ_I.nonarray &&
                                addr_q[ADDR_W-1:PAGE_BITS] ==
                                REQ_I.addr[ADDR_W-1:PAGE_BITS]) ?
                                C_APA : C_ACC;
                            if (after_write_q) begin
                                load_cnt = C_ACC + C_WHGL;
                            end
                        end
                    endcase
                end
            end
            ST_WSETUP: begin
                load = wait_done;
                load_cnt = C_WP;
            end
            ST_WPULSE: begin
                load = wait_done;
                load_cnt = C_WPH;
            end
            default: begin
                load = 1'b0;
                load_cnt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_RESET;
        end else begin
            case (state_q)
                ST_RESET: if (wait_done) state_q <= ST_RECOVER;
                ST_RECOVER: if (wait_done) state_q <= ST_IDLE;
                ST_IDLE: begin
                    if (accept) begin
                        case (REQ_I.op)
                            OP_WRITE: state_q <= ST_WSETUP;
                            OP_WIDTH: state_q <= ST_WIDTH;
                            OP_RESET: state_q <= ST_RESET;
                            default: state_q <= ST_RACC;
                        endcase
                    end
                end
                ST_WSETUP: if (wait_done) state_q <= ST_WPULSE;
                ST_WPULSE: if (wait_done) state_q <= ST_WHIGH;
                ST_WHIGH: if (wait_done) state_q <= ST_IDLE;
                ST_RACC: if (wait_done) state_q <= ST_RPAGE;
                ST_RPAGE: state_q <= ST_IDLE;
                ST_WIDTH: if (wait_done) state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Address, data and bookkeeping
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            addr_q <= '0;
            wdata_q <= 16'h0000;
            after_write_q <= 1'b0;
            page_open_q <= 1'b0;
            dq_oe_q <= 1'b0;
        end else begin
            if (accept) begin
                addr_q <= REQ_I.addr[ADDR_W-1:0];
                wdata_q <= REQ_I.wdata;
            end
            if (state_q == ST_WHIGH && wait_done) begin
                after_write_q <= 1'b1;
                page_open_q <= 1'b0;
            end else if (state_q == ST_RPAGE) begin
                after_write_q <= 1'b0;
                page_open_q <= PAGE_MODE;
            end else if (state_q == ST_RESET || state_q == ST_WIDTH) begin
                page_open_q <= 1'b0;
            end
            // Data driven only through setup and pulse
            dq_oe_q <= (state_q == ST_IDLE && accept &&
                REQ_I.op == OP_WRITE) || state_q == ST_WSETUP ||
                (state_q == ST_WPULSE && !wait_done);
        end
    end

    // Pin drive
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pins_q.cs <= `CS_DISABLE;
            pins_q.oe_n <= 1'b1;
            pins_q.we_n <= 1'b1;
            pins_q.rst_n <= 1'b0;
            pins_q.wide <= 1'b1;
        end else begin
            pins_q.rst_n <= !(state_q == ST_RESET);
            // Select spans a whole access
            // Select held while a page stays open
            pins_q.cs <= (state_q == ST_WSETUP || state_q == ST_WPULSE ||
                state_q == ST_RACC || (accept && REQ_I.op != OP_WIDTH &&
                REQ_I.op != OP_RESET) || (PAGE_MODE &&
                (state_q == ST_RPAGE || (state_q == ST_IDLE && !accept &&
                page_open_q)))) ? `CS_ENABLE : `CS_DISABLE;
            // Write strobe low only in pulse, never with read
            pins_q.we_n <= !((state_q == ST_WSETUP && wait_done) ||
                (state_q == ST_WPULSE && !wait_done));
            // Output enable with select; data waits full access, or page access on a page hit
            pins_q.oe_n <= !((accept && REQ_I.op == OP_READ) ||
                (state_q == ST_RACC && !wait_done));
            if (accept && REQ_I.op == OP_WIDTH) begin
                pins_q.wide <= !REQ_I.byte_mode;
            end
        end
    end

    // Read capture after access time
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            // Synchroniser lag: data sampled at last access edge
            rvalid_q <= (state_q == ST_RPAGE);
            if (state_q == ST_RPAGE) begin
                rdata_q <= pins_q.wide ? dq_sync_q :
                    {8'h00, dq_sync_q[7:0]};
            end
        end
    end

    // Ready/busy watch and program enable hold
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            sts_busy_q <= 1'b0;
            sts_cnt_q <= 8'h00;
            pe_q <= 1'b0;
        end else begin
            if (state_q == ST_WHIGH && wait_done) begin
                sts_cnt_q <= C_STS;
            end else if (sts_cnt_q != 8'h00) begin
                sts_cnt_q <= sts_cnt_q - 8'h01;
            end
            sts_busy_q <= (sts_cnt_q != 8'h00) || !sts_sync_q[1];
            pe_q <= PROG_ENABLE_REQ_I || (sts_cnt_q != 8'h00) ||
                !sts_sync_q[1];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            REQ_READY_O <= 1'b0;
        end else begin
            REQ_READY_O <= (state_q == ST_IDLE && !accept) ||
                (state_q == ST_RECOVER && wait_done) ||
                (state_q == ST_RPAGE) || (state_q == ST_WHIGH && wait_done) ||
                (state_q == ST_WIDTH && wait_done);
        end
    end

    assign FLASH_CHIP_SELECT_O = pins_q.cs;
    assign FLASH_OE_N_O = pins_q.oe_n;
    assign FLASH_WE_N_O = pins_q.we_n;
    assign FLASH_RESET_POWERDOWN_N_O = pins_q.rst_n;
    assign FLASH_WIDE_O = pins_q.wide;
    assign FLASH_ADDR_O = addr_q;
    assign FLASH_DQ_O = wdata_q;
    assign FLASH_DQ_OE_O = dq_oe_q;
    assign RDATA_O = rdata_q;
    assign RDATA_VALID_O = rvalid_q;
    assign FLASH_PROGRAM_ENABLE_INPUT_O = pe_q;
    assign BUSY_O = sts_busy_q;
endmodule
`default_nettype wire

// >>> tb/flash_host_asserts.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts #(
    parameter int DENSITY = 2,
    parameter int ADDR_W = 24
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic PROG_ENABLE_REQ_I,
    input wire logic FLASH_STATUS_OUTPUT_PIN_I,
    input wire logic [15:0] FLASH_DQ_O,
    input wire logic FLASH_DQ_OE_O,
    input wire logic [ADDR_W-1:0] FLASH_ADDR_O,
    input wire logic [2:0] FLASH_CHIP_SELECT_O,
    input wire logic FLASH_OE_N_O,
    input wire logic FLASH_WE_N_O,
    input wire logic FLASH_RESET_POWERDOWN_N_O,
    input wire logic FLASH_PROGRAM_ENABLE_INPUT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [3:0] rec_q;
    // Cycles since the reset pin went high
    always_ff @(posedge CLK_I) begin
        if (!FLASH_RESET_POWERDOWN_N_O) rec_q <= 4'h0;
        else if (rec_q != 4'hF) rec_q <= rec_q + 4'h1;
    end
    sequence s_wr_open; $fell(FLASH_WE_N_O); endsequence
    sequence s_wr_close; $rose(FLASH_WE_N_O); endsequence
    property p_cs_legal;
        FLASH_CHIP_SELECT_O == 3'h0 || FLASH_CHIP_SELECT_O == 3'h7;
    endproperty
    property p_framed;
        !FLASH_WE_N_O |-> FLASH_CHIP_SELECT_O == 3'h0 && FLASH_DQ_OE_O;
    endproperty
    property p_wp; s_wr_open |=> !FLASH_WE_N_O; endproperty
    property p_wph; s_wr_close |=> FLASH_WE_N_O; endproperty
    property p_setup;
        s_wr_open ##1 !FLASH_WE_N_O |->
            $stable(FLASH_ADDR_O) && $stable(FLASH_DQ_O);
    endproperty
    property p_recover;
        FLASH_CHIP_SELECT_O == 3'h0 |-> rec_q >= 3 + DENSITY;
    endproperty
    property p_wr_rec; $fell(FLASH_OE_N_O) |-> $past(FLASH_WE_N_O); endproperty
    property p_oe_sel;
        $fell(FLASH_OE_N_O) |-> FLASH_CHIP_SELECT_O == 3'h0;
    endproperty
    property p_excl; FLASH_OE_N_O || FLASH_WE_N_O; endproperty
    property p_pe_req;
        PROG_ENABLE_REQ_I |=> FLASH_PROGRAM_ENABLE_INPUT_O;
    endproperty
    property p_pe_busy;
        !FLASH_STATUS_OUTPUT_PIN_I [*4] |-> FLASH_PROGRAM_ENABLE_INPUT_O;
    endproperty
    a_cs_legal: assert property (p_cs_legal) else $error("bad select");
    a_framed: assert property (p_framed) else $error("unframed write");
    a_wp: assert property (p_wp) else $error("write pulse short");
    a_wph: assert property (p_wph) else $error("write high short");
    a_setup: assert property (p_setup) else $error("write setup");
    a_recover: assert property (p_recover) else $error("early cycle");
    a_wr_rec: assert property (p_wr_rec) else $error("read too soon");
    a_oe_sel: assert property (p_oe_sel) else $error("oe unselected");
    a_excl: assert property (p_excl) else $error("oe and we low");
    a_pe_req: assert property (p_pe_req) else $error("pe not held");
    a_pe_busy: assert property (p_pe_busy) else $error("pe dropped");
endmodule
bind flash_host flash_host_asserts #(.DENSITY(DENSITY), .ADDR_W(ADDR_W))
    flash_host_asserts_inst (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .PROG_ENABLE_REQ_I(PROG_ENABLE_REQ_I),
    .FLASH_STATUS_OUTPUT_PIN_I(FLASH_STATUS_OUTPUT_PIN_I),
    .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_O(FLASH_DQ_OE_O),
    .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_CHIP_SELECT_O(FLASH_CHIP_SELECT_O),
    .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O),
    .FLASH_RESET_POWERDOWN_N_O(FLASH_RESET_POWERDOWN_N_O),
    .FLASH_PROGRAM_ENABLE_INPUT_O(FLASH_PROGRAM_ENABLE_INPUT_O));
`default_nettype wire

// >>> tb/flash_device_model.sv
// Behavioural model of the clockless parallel flash
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
    parameter int T_PHQV = 210,
    parameter bit PAGE = 1'b1
) (
    input wire logic [2:0] cs_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rst_n_i,
    input wire logic wide_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic sts_o
);
    logic [15:0] mem [256];
    logic [20:0] pg;
    realtime ta, tp, te, tg, tr, tw;
    logic sel, ok;
    logic [15:0] w;
    assign sel = cs_i == 3'h0 && rst_n_i;
    assign w = mem[addr_i[7:0]];
    // Unready or floated bus shows inverted data
    assign dq_o = ok ? {wide_i ? w[15:8] : ~w[15:8], w[7:0]} : ~w;
    initial begin
        sts_o = 1'b1;
        ok = 1'b0;
        pg = '1;
        foreach (mem[i]) mem[i] = 16'h0000;
    end
    always @(addr_i) begin
        ta = $realtime;
        if (addr_i[23:3] != pg || !PAGE) tp = $realtime;
        pg = addr_i[23:3];
    end
    always @(sel) te = $realtime;
    always @(oe_n_i) tg = $realtime;
    always @(rst_n_i) tr = $realtime;
    always @(wide_i) tw = $realtime;
    // Read path ignores busy state
    always #5 ok = sel && !oe_n_i && $realtime - tp >= 75.0
        && $realtime - ta >= 25.0 && $realtime - te >= 75.0
        && $realtime - tg >= 25.0 && $realtime - tr >= T_PHQV
        && $realtime - tw >= 1000.0;
    always @(negedge we_n_i) begin
        #40;
        if (sel && oe_n_i) begin
            mem[addr_i[7:0]] = dq_i;
            sts_o <= #200 1'b0;
            sts_o <= #1000 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import flash_host_pkg::*;
    logic clk, rst, req_valid, pe_req, sts, req_ready, rvalid, dq_oe;
    logic oe_n, we_n, rst_n, wide, pe, busy;
    req_t req;
    logic [15:0] rdata, dq_h, dq_f, dq_bus;
    logic [23:0] addr;
    logic [2:0] cs;
    logic [15:0] shadow [256];
    logic [15:0] expq [$];
    logic [31:0] seed;
    logic [23:0] a;
    int err_total, check_count, n;
    assign dq_bus = dq_oe ? dq_h : dq_f;
    flash_host flash_host_inst (.CLK_I(clk), .SYS_RST_I(rst), .REQ_I(req),
        .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .RDATA_O(rdata),
        .RDATA_VALID_O(rvalid), .PROG_ENABLE_REQ_I(pe_req),
        .FLASH_DQ_I(dq_bus), .FLASH_DQ_O(dq_h), .FLASH_DQ_OE_O(dq_oe),
        .FLASH_STATUS_OUTPUT_PIN_I(sts), .FLASH_ADDR_O(addr),
        .FLASH_CHIP_SELECT_O(cs), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
        .FLASH_RESET_POWERDOWN_N_O(rst_n), .FLASH_WIDE_O(wide),
        .FLASH_PROGRAM_ENABLE_INPUT_O(pe), .BUSY_O(busy));
    flash_device_model flash_device_model_inst (.cs_i(cs), .oe_n_i(oe_n),
        .we_n_i(we_n), .rst_n_i(rst_n), .wide_i(wide), .addr_i(addr),
        .dq_i(dq_bus), .dq_o(dq_f), .sts_o(sts));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick();
        @(negedge clk);
        n++;
        if (n > 400) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic send(input op_t op, input logic [23:0] ad,
                        input logic bm, input logic na);
        n = 0;
        while (req_ready !== 1'b1) tick();
        seed = lfsr(seed);
        req = '{op: op, nonarray: na, byte_mode: bm, addr: ad,
                wdata: seed[15:0]};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        if (op == OP_WRITE) shadow[ad[7:0]] = seed[15:0];
        if (op == OP_READ) expq.push_back(bm ?
            {8'h00, shadow[ad[7:0]][7:0]} : shadow[ad[7:0]]);
        @(negedge clk);
    endtask
    task automatic drain();
        n = 0;
        while (expq.size() != 0 || req_ready !== 1'b1) tick();
    endtask
    always @(negedge clk) begin
        if (rvalid === 1'b1)
            chk(rdata, expq.size() ? expq.pop_front() : 16'hXXXX);
    end
    initial begin
        seed = 32'h01F8;
        rst = 1'b1;
        req_valid = 1'b0;
        pe_req = 1'b0;
        req = '0;
        err_total = 0;
        check_count = 0;
        foreach (shadow[i]) shadow[i] = 16'h0000;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        // Back-to-back writes, then a full page of reads
        for (int i = 0; i < 8; i++) send(OP_WRITE, 24'h40 + i, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) send(OP_READ, 24'h40 + i, 1'b0, i[0]);
        drain();
        $display("page test done");
        // Write then read back while the device is busy
        send(OP_WRITE, 24'h13, 1'b0, 1'b0);
        send(OP_READ, 24'h13, 1'b0, 1'b0);
        n = 0;
        while (sts !== 1'b0) tick();
        repeat (4) @(negedge clk);
        chk({15'h0, pe}, 16'h0001);
        chk({15'h0, busy}, 16'h0001);
        pe_req = 1'b1;
        drain();
        pe_req = 1'b0;
        $display("busy test done");
        // Narrow bus with byte reads
        send(OP_WIDTH, 24'h0, 1'b1, 1'b0);
        drain();
        chk({15'h0, wide}, 16'h0000);
        send(OP_READ, 24'h41, 1'b1, 1'b0);
        send(OP_WIDTH, 24'h0, 1'b0, 1'b0);
        send(OP_READ, 24'h42, 1'b0, 1'b0);
        drain();
        chk({15'h0, wide}, 16'h0001);
        $display("width test done");
        // Pin reset, then a controller reset mid-run
        send(OP_RESET, 24'h0, 1'b0, 1'b0);
        send(OP_READ, 24'h43, 1'b0, 1'b0);
        drain();
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        send(OP_READ, 24'h13, 1'b0, 1'b1);
        drain();
        $display("reset test done");
        // Random addresses and data
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = {16'h0, seed[23:16]};
            send(OP_WRITE, a, 1'b0, 1'b0);
            send(OP_READ, a, 1'b0, 1'b0);
        end
        drain();
        $display("random test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
